// ===== rtl/cpu_status_flag_consts.vh
// Constants of the status word and flag datapath
// Summary of operation
// - Reset sets interrupt-disable flag, others free
// - Push stores status at S, pull restores from S+1
// - Set-decimal makes add and subtract packed decimal
// - Decimal N, V, Z flags are not valid
// - Decimal carry flag reports carry or borrow
// - Multiply and divide ignore memory and decimal flags
// - Multiply and divide leave status word unchanged
// - Bit, shift, rotate, step, complement do read-modify-write
// - Memory-operand flag makes logic/arith read-modify-write
// - Unreadable register reads return undefined value
`ifndef CPU_STATUS_FLAG_CONSTS_VH
`define CPU_STATUS_FLAG_CONSTS_VH

// =========================================
// Register byte addresses
`define A_CMD 8'h00
`define A_ACC 8'h04
`define A_STAT 8'h08
`define A_ADDR 8'h0c
`define A_OPB 8'h10
`define A_SP 8'h14
`define A_RES 8'h18
`define A_BUSY 8'h1c
`define MEM_SEL 3'h2
`define ZPAD 24'h000000

// =========================================
// Status word bit positions and reset values
`define F_C 0
`define F_Z 1
`define F_I 2
`define F_D 3
`define F_B 4
`define F_T 5
`define F_V 6
`define F_N 7
`define ST_RST 8'h04
`define SP_RST 3'h7
`define UNREAD_IDX 3'h7
`define UNDEF_VAL 8'h5a
`define BCD_MAX 5'h09
`define BCD_ADJ 5'h06

// =========================================
// Operation codes
`define OP_NOP 5'h00
`define OP_CSET 5'h01
`define OP_CCLR 5'h02
`define OP_DSET 5'h03
`define OP_DCLR 5'h04
`define OP_SET 5'h05
`define OP_CLT 5'h06
`define OP_PUSH 5'h07
`define OP_PULL 5'h08
`define OP_ADC 5'h09
`define OP_SUB 5'h0a
`define OP_AND 5'h0b
`define OP_XOR 5'h0c
`define OP_IOR 5'h0d
`define OP_BSET 5'h0e
`define OP_BCLR 5'h0f
`define OP_SHL 5'h10
`define OP_SHR 5'h11
`define OP_RTL 5'h12
`define OP_RTR 5'h13
`define OP_NSWAP 5'h14
`define OP_INC 5'h15
`define OP_STEPDN 5'h16
`define OP_COM 5'h17
`define OP_PROD 5'h18
`define OP_DIV 5'h19

// =========================================
// Sequencer states
`define S_IDLE 2'h0
`define S_RD 2'h1
`define S_WR 2'h2

`endif

// ===== rtl/cpu_status_flag_datapath.v
// Status word and flag datapath of an 8-bit core, with APB register access
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "cpu_status_flag_consts.vh"

module cpu_status_flag_datapath (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [7:0] cpuStatusWord,
    output reg busy
);

// =========================================
// State
reg [7:0] acc_ff;
reg [7:0] opB_ff;
reg [7:0] res_ff;
reg [2:0] addr_ff;
reg [2:0] sp_ff;
reg [4:0] op_ff;
reg [2:0] bit_ff;
reg [1:0] state_ff;
reg [7:0] rdVal_ff;
reg [7:0] mem_ff [0:7];
integer i;

// =========================================
// Functions

// Index holds a readable byte
function isReadable;
    input [2:0] idx;
    begin
        isReadable = (idx != `UNREAD_IDX);
    end
endfunction

// Packed decimal add or subtract, carry out in bit 8
function [8:0] decAdj;
    input [7:0] a;
    input [7:0] b;
    input cin;
    input sub;
    reg [4:0] lo;
    reg [4:0] hi;
    reg lc;
    reg hc;
    begin
        if (!sub) begin
            lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            lc = (lo > `BCD_MAX);
            lo = lc ? (lo + `BCD_ADJ) : lo;
            hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lc};
            hc = (hi > `BCD_MAX);
            hi = hc ? (hi + `BCD_ADJ) : hi;
            decAdj = {hc, hi[3:0], lo[3:0]};
        end else begin
            lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
            lc = lo[4];
            lo = lc ? (lo - `BCD_ADJ) : lo;
            hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lc};
            hc = hi[4];
            hi = hc ? (hi - `BCD_ADJ) : hi;
            decAdj = {~hc, hi[3:0], lo[3:0]};
        end
    end
endfunction

// =========================================
// APB decode
wire apbAcc = psel & penable & ~pready;
wire apbDone = psel & penable & pready;
wire memWin = (paddr[7:5] == `MEM_SEL);
wire mapped = (paddr[1:0] == 2'b00) & ((paddr <= `A_BUSY) | memWin);
wire wrOk = apbDone & pwrite & mapped & ~busy;
wire tMode = cpuStatusWord[`F_T];
wire carryIn = cpuStatusWord[`F_C];

// Read data selection
reg [31:0] rdMux;
always @* begin
    rdMux = 32'h00000000;
    if (memWin) begin
        if (isReadable(paddr[4:2])) begin
            rdMux = {`ZPAD, mem_ff[paddr[4:2]]};
        end else begin
            rdMux = {`ZPAD, `UNDEF_VAL};
        end
    end else begin
        case (paddr)
            `A_CMD: rdMux = {`ZPAD, bit_ff, op_ff};
            `A_ACC: rdMux = {`ZPAD, acc_ff};
            `A_STAT: rdMux = {`ZPAD, cpuStatusWord};
            `A_ADDR: rdMux = {29'h00000000, addr_ff};
            `A_OPB: rdMux = {`ZPAD, opB_ff};
            `A_SP: rdMux = {29'h00000000, sp_ff};
            `A_RES: rdMux = {`ZPAD, res_ff};
            `A_BUSY: rdMux = {30'h00000000, state_ff};
            default: rdMux = 32'h00000000;
        endcase
    end
end

// =========================================
// Operation execute

// Byte fetched in the read step: stack top for pull, else operand
wire [2:0] rdIdx = (op_ff == `OP_PULL) ? (sp_ff + 3'h1) : addr_ff;

reg [7:0] nxtAcc;
reg [7:0] nxtSt;
reg [7:0] nxtMem;
reg [7:0] nxtRes;
reg [2:0] nxtSp;
reg [2:0] wrIdx;
reg memWe;
reg toMem;
reg toAcc;
reg setNz;
reg [7:0] r;
reg [7:0] opX;
reg [7:0] opY;
reg [8:0] sum9;
reg [15:0] prod;

// Memory flag picks destination and sources
always @* begin
    opX = tMode ? rdVal_ff : acc_ff;
    opY = tMode ? opB_ff : rdVal_ff;
end

// Result, flags and destination per operation
always @* begin
    nxtAcc = acc_ff;
    nxtSt = cpuStatusWord;
    nxtMem = rdVal_ff;
    nxtRes = res_ff;
    nxtSp = sp_ff;
    wrIdx = addr_ff;
    memWe = 1'b0;
    toMem = 1'b0;
    toAcc = 1'b0;
    setNz = 1'b0;
    r = rdVal_ff;
    sum9 = 9'h000;
    prod = 16'h0000;
    case (op_ff)
        `OP_CSET: nxtSt[`F_C] = 1'b1;
        `OP_CCLR: nxtSt[`F_C] = 1'b0;
        `OP_DSET: nxtSt[`F_D] = 1'b1;
        `OP_DCLR: nxtSt[`F_D] = 1'b0;
        `OP_SET: nxtSt[`F_T] = 1'b1;
        `OP_CLT: nxtSt[`F_T] = 1'b0;
        `OP_PUSH: begin
            memWe = 1'b1;
            wrIdx = sp_ff;
            nxtMem = cpuStatusWord;
            nxtSp = sp_ff - 3'h1;
        end
        `OP_PULL: begin
            nxtSt = rdVal_ff;
            nxtSp = sp_ff + 3'h1;
        end
        `OP_ADC, `OP_SUB: begin
            if (cpuStatusWord[`F_D]) begin
                // N, V, Z hold their old values here
                sum9 = decAdj(opX, opY, carryIn, op_ff == `OP_SUB);
                r = sum9[7:0];
                nxtSt[`F_C] = sum9[8];
            end else if (op_ff == `OP_ADC) begin
                sum9 = {1'b0, opX} + {1'b0, opY} + {8'h00, carryIn};
                r = sum9[7:0];
                nxtSt[`F_C] = sum9[8];
                nxtSt[`F_V] = (opX[7] == opY[7]) & (r[7] != opX[7]);
                setNz = 1'b1;
            end else begin
                sum9 = {1'b0, opX} - {1'b0, opY} - {8'h00, ~carryIn};
                r = sum9[7:0];
                nxtSt[`F_C] = ~sum9[8];
                nxtSt[`F_V] = (opX[7] != opY[7]) & (r[7] != opX[7]);
                setNz = 1'b1;
            end
            toMem = tMode;
            toAcc = ~tMode;
        end
        `OP_AND, `OP_XOR, `OP_IOR: begin
            r = (op_ff == `OP_AND) ? (opX & opY) :
                ((op_ff == `OP_XOR) ? (opX ^ opY) : (opX | opY));
            setNz = 1'b1;
            toMem = tMode;
            toAcc = ~tMode;
        end
        `OP_BSET: begin
            r = rdVal_ff | (8'h01 << bit_ff);
            toMem = 1'b1;
        end
        `OP_BCLR: begin
            r = rdVal_ff & ~(8'h01 << bit_ff);
            toMem = 1'b1;
        end
        `OP_SHL: begin
            r = {rdVal_ff[6:0], 1'b0};
            nxtSt[`F_C] = rdVal_ff[7];
            setNz = 1'b1;
            toMem = 1'b1;
        end
        `OP_SHR: begin
            r = {1'b0, rdVal_ff[7:1]};
            nxtSt[`F_C] = rdVal_ff[0];
            setNz = 1'b1;
            toMem = 1'b1;
        end
        `OP_RTL: begin
            r = {rdVal_ff[6:0], carryIn};
            nxtSt[`F_C] = rdVal_ff[7];
            setNz = 1'b1;
            toMem = 1'b1;
        end
        `OP_RTR: begin
            r = {carryIn, rdVal_ff[7:1]};
            nxtSt[`F_C] = rdVal_ff[0];
            setNz = 1'b1;
            toMem = 1'b1;
        end
        `OP_NSWAP: begin
            r = {rdVal_ff[3:0], rdVal_ff[7:4]};
            toMem = 1'b1;
        end
        `OP_INC: begin
            r = rdVal_ff + 8'h01;
            setNz = 1'b1;
            toMem = 1'b1;
        end
        `OP_STEPDN: begin
            r = rdVal_ff - 8'h01;
            setNz = 1'b1;
            toMem = 1'b1;
        end
        `OP_COM: begin
            r = ~rdVal_ff;
            setNz = 1'b1;
            toMem = 1'b1;
        end
        `OP_PROD: begin
            // Neither memory nor decimal flag is consulted
            prod = acc_ff * opB_ff;
            nxtAcc = prod[7:0];
            nxtRes = prod[15:8];
        end
        `OP_DIV: begin
            if (opB_ff == 8'h00) begin
                nxtAcc = 8'hff; // Divide by zero saturates
                nxtRes = acc_ff;
            end else begin
                nxtAcc = acc_ff / opB_ff;
                nxtRes = acc_ff % opB_ff;
            end
        end
        default: r = rdVal_ff;
    endcase
    if (setNz) begin
        nxtSt[`F_N] = r[7];
        nxtSt[`F_Z] = (r == 8'h00);
    end
    if (toMem) begin
        memWe = 1'b1;
        nxtMem = r;
    end
    if (toAcc) begin
        nxtAcc = r;
    end
    if ((op_ff == `OP_PROD) || (op_ff == `OP_DIV)) begin
        nxtSt = cpuStatusWord;
    end
end

// =========================================
// Registers, bus slave and sequencer

// One wait state on every APB access; writes land with pready
always @(posedge clk) begin
    if (srst) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        cpuStatusWord <= `ST_RST;
        busy <= 1'b0;
        acc_ff <= 8'h00;
        opB_ff <= 8'h00;
        res_ff <= 8'h00;
        addr_ff <= 3'h0;
        sp_ff <= `SP_RST;
        op_ff <= `OP_NOP;
        bit_ff <= 3'h0;
        state_ff <= `S_IDLE;
        rdVal_ff <= 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            mem_ff[i] <= 8'h00;
        end
    end else if (ce) begin
        pready <= apbAcc;
        pslverr <= apbAcc & ~mapped;
        if (apbAcc) begin
            prdata <= rdMux;
        end
        // Plain register writes, refused while an operation runs
        if (wrOk) begin
            if (memWin) begin
                mem_ff[paddr[4:2]] <= pwdata[7:0];
            end else begin
                case (paddr)
                    `A_ACC: acc_ff <= pwdata[7:0];
                    `A_STAT: cpuStatusWord <= pwdata[7:0];
                    `A_ADDR: addr_ff <= pwdata[2:0];
                    `A_OPB: opB_ff <= pwdata[7:0];
                    `A_SP: sp_ff <= pwdata[2:0];
                    default: acc_ff <= acc_ff;
                endcase
            end
        end
        // Read, then modify and write back
        case (state_ff)
            `S_IDLE: begin
                if (wrOk && (paddr == `A_CMD)) begin
                    op_ff <= pwdata[4:0];
                    bit_ff <= pwdata[7:5];
                    busy <= 1'b1;
                    state_ff <= `S_RD;
                end
            end
            `S_RD: begin
                if (isReadable(rdIdx)) begin
                    rdVal_ff <= mem_ff[rdIdx];
                end else begin
                    rdVal_ff <= `UNDEF_VAL;
                end
                state_ff <= `S_WR;
            end
            `S_WR: begin
                acc_ff <= nxtAcc;
                cpuStatusWord <= nxtSt;
                res_ff <= nxtRes;
                sp_ff <= nxtSp;
                if (memWe) begin
                    mem_ff[wrIdx] <= nxtMem;
                end
                busy <= 1'b0;
                state_ff <= `S_IDLE;
            end
            default: begin
                busy <= 1'b0;
                state_ff <= `S_IDLE;
            end
        endcase
    end
end

endmodule // cpu_status_flag_datapath

// ===== sim/cpu_status_flag_properties.sv
// Checker of handshake and status flag timing
`timescale 1ns/1ps
`include "cpu_status_flag_consts.vh"
module cpu_status_flag_properties (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] cpuStatusWord,
    input wire busy
);
    // =========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Accepted command write
    wire cmdWr = psel && penable && pready && pwrite && paddr == `A_CMD && !busy;
    irq_flag_set_a: assert property ($fell(srst) |-> cpuStatusWord[`F_I])
        else $error("interrupt flag clear after reset");
    wait_state_a: assert property (ce && psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    ready_pulse_a: assert property (ce && pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
        else $error("ready without access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    decimal_set_a: assert property (cmdWr && pwdata[4:0] == `OP_DSET |-> ##[1:3] cpuStatusWord[`F_D])
        else $error("decimal flag not set");
    muldiv_keep_a: assert property (cmdWr && (pwdata[4:0] == `OP_PROD || pwdata[4:0] == `OP_DIV)
        |=> $stable(cpuStatusWord)[*3])
        else $error("status changed by multiply or divide");
    // Two enabled cycles after busy rises finish an operation
    busy_bound_a: assert property ($rose(busy) && ce ##1 ce |=> !busy)
        else $error("operation too long");
endmodule // cpu_status_flag_properties

bind cpu_status_flag_datapath cpu_status_flag_properties cpu_status_flag_properties_inst (
    .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuStatusWord(cpuStatusWord), .busy(busy));

// ===== sim/tb.sv
// Self-checking bench of the status flag datapath
`timescale 1ns/1ps
`include "cpu_status_flag_consts.vh"
module tb;
    reg clk, srst, ce, psel, penable, pwrite;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    wire [31:0] prdata;
    wire pready, pslverr, busy;
    wire [7:0] cpuStatusWord;
    logic [32:0] expQ[$];
    logic [39:0] dt[4];
    logic [7:0] a, m, o, r, s;
    logic [15:0] d;
    int bad_count, n_tests, i;
    cpu_status_flag_datapath cpu_status_flag_datapath_inst (.clk(clk), .srst(srst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuStatusWord(cpuStatusWord),
        .busy(busy));
    // =========================================
    // Clock and helpers
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task summarize;
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // One APB transfer, held until ready
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad_count++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] v);
        apb(1'b1, ad, {24'h0, v});
    endtask
    task rd(input logic [7:0] ad, input logic [7:0] e);
        expQ.push_back({25'h0, e});
        apb(1'b0, ad, 32'h0);
    endtask
    // Start an operation and wait for it to finish
    task op(input logic [7:0] c);
        int k;
        wr(`A_CMD, c);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((busy !== 1'b0 || k < 3) && k < 20);
        if (k >= 20) begin
            bad_count++;
            summarize();
        end
    endtask
    // Read results compared in order
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) chk(expQ.pop_front(), {pslverr, prdata});
    end
    // =========================================
    // Main sequence
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        dt[0] = {8'h09, 8'h45, 8'h38, 8'h83, 8'h00};
        dt[1] = {8'h09, 8'h58, 8'h46, 8'h05, 8'h03};
        dt[2] = {8'h0a, 8'h50, 8'h21, 8'h29, 8'h03};
        dt[3] = {8'h0a, 8'h21, 8'h50, 8'h71, 8'h02};
        void'($urandom(32'h824d31de));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        chk(33'h4, {25'h0, cpuStatusWord});
        rd(`A_STAT, 8'h04);
        wr(`A_STAT, 8'h04);
        op(`OP_DSET);
        wr(`A_ADDR, 8'h00);
        // Packed decimal add and subtract
        for (i = 0; i < 4; i++) begin
            wr(`A_ACC, dt[i][31:24]);
            wr(8'h40, dt[i][23:16]);
            op(dt[i][1] ? `OP_CSET : `OP_CCLR);
            op(dt[i][39:32]);
            op(`OP_NOP);
            rd(`A_ACC, dt[i][15:8]);
            rd(`A_STAT, {7'h06, dt[i][0]});
            rd(8'h40, dt[i][23:16]);
        end
        // Memory-operand flag set: result goes to memory
        op(`OP_DCLR);
        op(`OP_SET);
        for (i = 0; i < 5; i++) begin
            m = 8'($urandom);
            o = 8'($urandom);
            a = 8'($urandom);
            wr(8'h40, m);
            wr(`A_OPB, o);
            wr(`A_ACC, a);
            op(i == 1 ? `OP_CSET : `OP_CCLR);
            op(8'(`OP_ADC + i));
            case (i)
                0: r = m + o;
                1: r = m - o;
                2: r = m & o;
                3: r = m ^ o;
                default: r = m | o;
            endcase
            rd(8'h40, r);
            rd(`A_ACC, a);
        end
        // Read-modify-write operations on memory
        for (i = 0; i < 10; i++) begin
            m = 8'($urandom);
            o = 8'($urandom);
            s = 8'($urandom % 7);
            wr(`A_ADDR, s);
            wr({3'b010, s[2:0], 2'b00}, m);
            op(`OP_CCLR);
            op({o[2:0], 5'(`OP_BSET + i)});
            case (i)
                0: r = m | (8'h01 << o[2:0]);
                1: r = m & ~(8'h01 << o[2:0]);
                2, 4: r = {m[6:0], 1'b0};
                3, 5: r = {1'b0, m[7:1]};
                6: r = {m[3:0], m[7:4]};
                7: r = m + 8'h01;
                8: r = m - 8'h01;
                default: r = ~m;
            endcase
            rd({3'b010, s[2:0], 2'b00}, r);
        end
        // Multiply and divide with memory and decimal flags set
        for (i = 0; i < 2; i++) begin
            a = 8'($urandom);
            o = 8'($urandom) | 8'h01;
            wr(`A_STAT, 8'h2d);
            wr(`A_ACC, a);
            wr(`A_OPB, o);
            op(8'(`OP_PROD + i));
            if (i == 0) d = a * o;
            else d = {a % o, a / o};
            rd(`A_ACC, d[7:0]);
            rd(`A_RES, d[15:8]);
            rd(`A_STAT, 8'h2d);
        end
        // Divide by zero saturates, then memory flag cleared
        wr(`A_OPB, 8'h00);
        op(`OP_DIV);
        rd(`A_ACC, 8'hff);
        rd(`A_RES, d[7:0]);
        rd(`A_STAT, 8'h2d);
        op(`OP_CLT);
        rd(`A_STAT, 8'h0d);
        // Status push and pull through the stack
        s = 8'($urandom);
        wr(`A_STAT, s);
        wr(`A_SP, 8'h05);
        op(`OP_PUSH);
        rd(8'h54, s);
        rd(`A_SP, 8'h04);
        wr(`A_STAT, ~s);
        op(`OP_PULL);
        rd(`A_STAT, s);
        // Clock enable low freezes a running operation
        wr(`A_STAT, `ST_RST);
        wr(`A_CMD, {3'h0, `OP_CSET});
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        chk(33'h1, {32'h0, busy});
        chk({25'h0, `ST_RST}, {25'h0, cpuStatusWord});
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk(33'h0, {32'h0, busy});
        rd(`A_STAT, 8'h05);
        // Reset while idle restores status word and stack pointer
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(`A_STAT, `ST_RST);
        rd(`A_SP, {5'h00, `SP_RST});
        // Unreadable register and unmapped address
        rd(8'h5c, 8'h5a);
        expQ.push_back(33'h100000000);
        apb(1'b0, 8'h30, 32'h0);
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule // tb
